// *** verilog/ssr_setpoint_ramp.v ***
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "ssr_defines.vh"

// Overview of operation
// R1: up to four local setpoint groups; group count limits selectable numbers
// R2: each group names a control constant group; selection drives it out
// R3: groups sharing one constant group number output identical constants
// R4: selection value n picks setpoint group n
// R5: unit codes 0..11: resolution 1..0.001, each over second, minute, hour
// R6: local rise and fall rates 0 (step) or 1..32000 per time base
// R7: remote rise and fall rates 0 (step) or 1..32000 per time base
// R8: working setpoint moves at rise rate upward, fall rate downward
// R9: local ramp starts on value change, group change, remote to local
// R10: remote ramp starts on value change or local to remote
// R11: after power-on, manual to auto, ready to run, loop type change: start at process value
// R12: manual, ready or contact inhibit blocks and aborts any ramp
// R13: process value with range error is never a ramp start point
// R14: local process value start flag 1 forces start from previous setpoint
// R15: remote process value start flag 1 forces start from previous setpoint
// R16: contact operation 42 inhibits ramping for all loops or one loop
// R17: contact group select: sum 0 picks group 1, sum s picks 1+s, sums of 3 or more pick group 4
// R18: each tick adds or subtracts the rate and stops exactly at target
module ssr_setpoint_ramp #(
  parameter [27:0] SEC_CYCLES = `SSR_SEC_CYCLES,
  parameter [6:0] LOOP_ID = 7'h01
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // process value
  input wire [15:0] process_value,
  input wire proc_range_err,
  // internal contact inputs
  input wire contact_on,
  input wire [6:0] contact_op,
  input wire [6:0] contact_target,
  input wire contact_grp_valid,
  input wire [7:0] contact_grp_sum,
  // setpoint outputs
  output reg [15:0] working_setpoint,
  output reg [2:0] active_group,
  output reg [2:0] control_constant_group,
  output wire ramping
);

  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RAMP = 2'b10;

  reg [11:0] mode_r;
  reg [2:0] grp_count_r;
  reg [2:0] grp_sel_r;
  reg [3:0] unit_r;
  reg [14:0] loc_up_r;
  reg [14:0] loc_dn_r;
  reg [14:0] rem_up_r;
  reg [14:0] rem_dn_r;
  reg [15:0] remote_setpoint_r;
  reg [15:0] local_setpoint_r [0:3];
  reg [2:0] cgrp_r [0:3];

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [15:0] work_nxt;
  reg [15:0] prev_target_r;
  reg [1:0] prev_idx_r;
  reg prev_remote_r;
  reg prev_auto_r;
  reg prev_run_r;
  reg [3:0] prev_ltype_r;
  reg proc_pend_r;
  reg [2:0] sel_raw;
  reg [2:0] sel_eff;
  reg [14:0] rate_now;
  reg [16:0] abs_diff;

  wire remote_mode = mode_r[`SSR_MODE_REMOTE];
  wire auto_mode = mode_r[`SSR_MODE_AUTO];
  wire run_mode = mode_r[`SSR_MODE_RUN];
  wire [3:0] loop_type = mode_r[`SSR_MODE_LTYPE_HI:`SSR_MODE_LTYPE_LO];
  wire tick;

  // clamp a written rate to the legal span
  function [14:0] clamp_rate;
    input [31:0] v;
    begin
      if (v > {17'h00000, `SSR_RATE_MAX})
        clamp_rate = `SSR_RATE_MAX;
      else
        clamp_rate = v[14:0];
    end
  endfunction

  // group selection, contact inputs take precedence when valid
  always @* begin
    if (contact_grp_valid) begin
      if (contact_grp_sum >= 8'h03)
        sel_raw = `SSR_GRP_MAX;
      else
        sel_raw = contact_grp_sum[2:0] + 3'h1; // R17
    end else begin
      sel_raw = grp_sel_r; // R4
    end
    if (sel_raw == 3'h0)
      sel_eff = 3'h1;
    else if (sel_raw > grp_count_r)
      sel_eff = grp_count_r; // R1
    else
      sel_eff = sel_raw;
  end

  wire [1:0] grp_idx = sel_eff[1:0] - 2'h1;
  wire [15:0] target = remote_mode ? remote_setpoint_r : local_setpoint_r[grp_idx];

  // contact inhibit for all loops or this loop
  wire contact_inhibit = contact_on && (contact_op == `SSR_RAMP_OPCODE) &&
    ((contact_target == `SSR_TARGET_ALL) || (contact_target == LOOP_ID)); // R16
  wire inhibit = !auto_mode || !run_mode || contact_inhibit; // R12

  wire mode_chg = remote_mode != prev_remote_r;
  wire start_ev = (target != prev_target_r) || (grp_idx != prev_idx_r && !remote_mode) ||
    mode_chg; // R9 R10
  wire start_go = (start_ev || proc_pend_r) && !inhibit;
  wire proc_block = remote_mode ? mode_r[`SSR_MODE_REM_NOPROC] : mode_r[`SSR_MODE_LOC_NOPROC];
  wire proc_ok = proc_pend_r && !proc_range_err && !proc_block; // R11 R13 R14 R15
  wire [15:0] start_point = proc_ok ? process_value : working_setpoint;
  wire proc_set = (auto_mode && !prev_auto_r) || (run_mode && !prev_run_r) ||
    (loop_type != prev_ltype_r); // R11

  wire signed [16:0] diff = $signed({target[15], target}) -
    $signed({working_setpoint[15], working_setpoint});
  wire going_up = diff > 17'sd0;

  // rate by direction and by source
  always @* begin
    if (remote_mode)
      rate_now = going_up ? rem_up_r : rem_dn_r; // R7 R8
    else
      rate_now = going_up ? loc_up_r : loc_dn_r; // R6 R8
    abs_diff = diff[16] ? (17'h00000 - diff) : diff;
  end

  assign ramping = state_r[1];

  ssr_ramp_tick #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_tick (
    .clock(clock),
    .rst_n(rst_n),
    .unit_code(unit_r), // R5
    .restart(start_go),
    .tick(tick)
  );

  // ramp sequencing
  always @* begin
    state_nxt = state_r;
    work_nxt = working_setpoint;
    case (state_r)
      ST_IDLE: begin
        if (inhibit) begin
          work_nxt = target;
        end else if (start_go) begin
          work_nxt = start_point;
          state_nxt = ST_RAMP;
        end else begin
          work_nxt = target;
        end
      end
      ST_RAMP: begin
        if (inhibit) begin
          work_nxt = target; // R12
          state_nxt = ST_IDLE;
        end else if (start_go) begin
          work_nxt = start_point;
        end else if (rate_now == 15'h0000 || diff == 17'sd0) begin
          work_nxt = target;
          state_nxt = ST_IDLE;
        end else if (tick) begin
          if (abs_diff <= {2'b00, rate_now}) begin
            work_nxt = target; // R18
            state_nxt = ST_IDLE;
          end else if (going_up) begin
            work_nxt = working_setpoint + {1'b0, rate_now}; // R18
          end else begin
            work_nxt = working_setpoint - {1'b0, rate_now}; // R18
          end
        end
      end
      default: begin
        state_nxt = ST_IDLE;
        work_nxt = target;
      end
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      working_setpoint <= 16'h0000;
      prev_target_r <= 16'h0000;
      prev_idx_r <= 2'h0;
      prev_remote_r <= 1'b0;
      prev_auto_r <= 1'b1;
      prev_run_r <= 1'b1;
      prev_ltype_r <= 4'h0;
      proc_pend_r <= 1'b1;
      active_group <= `SSR_GRP_SEL_RST;
      control_constant_group <= `SSR_CGRP_RST;
    end else begin
      state_r <= state_nxt;
      working_setpoint <= work_nxt;
      prev_target_r <= target;
      prev_idx_r <= grp_idx;
      prev_remote_r <= remote_mode;
      prev_auto_r <= auto_mode;
      prev_run_r <= run_mode;
      prev_ltype_r <= loop_type;
      if (proc_set)
        proc_pend_r <= 1'b1;
      else if (start_go)
        proc_pend_r <= 1'b0;
      active_group <= sel_eff;
      control_constant_group <= cgrp_r[grp_idx]; // R2 R3
    end
  end

  // scalar configuration registers
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= `SSR_MODE_RST;
      grp_count_r <= `SSR_GRP_COUNT_RST;
      grp_sel_r <= `SSR_GRP_SEL_RST;
      unit_r <= `SSR_UNIT_RST;
      loc_up_r <= `SSR_RATE_RST;
      loc_dn_r <= `SSR_RATE_RST;
      rem_up_r <= `SSR_RATE_RST;
      rem_dn_r <= `SSR_RATE_RST;
      remote_setpoint_r <= 16'h0000;
    end else if (reg_wr) begin
      case (reg_addr)
        `SSR_ADDR_MODE: mode_r <= reg_wdata[11:0];
        `SSR_ADDR_GROUP: begin
          if (reg_wdata[`SSR_GRP_COUNT_HI:`SSR_GRP_COUNT_LO] > `SSR_GRP_MAX)
            grp_count_r <= `SSR_GRP_MAX;
          else if (reg_wdata[`SSR_GRP_COUNT_HI:`SSR_GRP_COUNT_LO] == 3'h0)
            grp_count_r <= 3'h1;
          else
            grp_count_r <= reg_wdata[`SSR_GRP_COUNT_HI:`SSR_GRP_COUNT_LO]; // R1
          grp_sel_r <= reg_wdata[`SSR_GRP_SEL_HI:`SSR_GRP_SEL_LO];
        end
        `SSR_ADDR_UNIT: begin
          if (reg_wdata[3:0] <= `SSR_UNIT_MAX)
            unit_r <= reg_wdata[3:0]; // R5
        end
        `SSR_ADDR_LOC_UP: loc_up_r <= clamp_rate(reg_wdata); // R6
        `SSR_ADDR_LOC_DN: loc_dn_r <= clamp_rate(reg_wdata); // R6
        `SSR_ADDR_REM_UP: rem_up_r <= clamp_rate(reg_wdata); // R7
        `SSR_ADDR_REM_DN: rem_dn_r <= clamp_rate(reg_wdata); // R7
        `SSR_ADDR_REMOTE: remote_setpoint_r <= reg_wdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // per-group setpoint value and constant group number
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : gen_grp
      wire [31:0] val_a = `SSR_ADDR_LOCAL0 + 4 * g;
      wire [31:0] cgrp_a = `SSR_ADDR_CGRP0 + 4 * g;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          local_setpoint_r[g] <= 16'h0000;
          cgrp_r[g] <= `SSR_CGRP_RST;
        end else if (reg_wr) begin
          if (reg_addr == val_a[7:0])
            local_setpoint_r[g] <= reg_wdata[15:0];
          if (reg_addr == cgrp_a[7:0])
            cgrp_r[g] <= reg_wdata[2:0]; // R2
        end
      end
    end
  endgenerate

  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `SSR_ADDR_MODE: reg_rdata <= {20'h00000, mode_r};
        `SSR_ADDR_GROUP: reg_rdata <= {25'h0000000, grp_sel_r, 1'b0, grp_count_r};
        `SSR_ADDR_UNIT: reg_rdata <= {28'h0000000, unit_r};
        `SSR_ADDR_LOC_UP: reg_rdata <= {17'h00000, loc_up_r};
        `SSR_ADDR_LOC_DN: reg_rdata <= {17'h00000, loc_dn_r};
        `SSR_ADDR_REM_UP: reg_rdata <= {17'h00000, rem_up_r};
        `SSR_ADDR_REM_DN: reg_rdata <= {17'h00000, rem_dn_r};
        `SSR_ADDR_REMOTE: reg_rdata <= {16'h0000, remote_setpoint_r};
        8'h20: reg_rdata <= {16'h0000, local_setpoint_r[0]};
        8'h24: reg_rdata <= {16'h0000, local_setpoint_r[1]};
        8'h28: reg_rdata <= {16'h0000, local_setpoint_r[2]};
        8'h2c: reg_rdata <= {16'h0000, local_setpoint_r[3]};
        8'h30: reg_rdata <= {29'h00000000, cgrp_r[0]};
        8'h34: reg_rdata <= {29'h00000000, cgrp_r[1]};
        8'h38: reg_rdata <= {29'h00000000, cgrp_r[2]};
        8'h3c: reg_rdata <= {29'h00000000, cgrp_r[3]};
        `SSR_ADDR_WORK: reg_rdata <= {16'h0000, working_setpoint};
        `SSR_ADDR_STATUS:
          reg_rdata <= {21'h000000, control_constant_group, 1'b0, active_group, 3'h0, ramping};
        default: reg_rdata <= 32'h00000000;
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule

// *** shared/ssr_defines.vh ***
`ifndef SSR_DEFINES_VH
`define SSR_DEFINES_VH

// register addresses
`define SSR_ADDR_MODE 8'h00
`define SSR_ADDR_GROUP 8'h04
`define SSR_ADDR_UNIT 8'h08
`define SSR_ADDR_LOC_UP 8'h0c
`define SSR_ADDR_LOC_DN 8'h10
`define SSR_ADDR_REM_UP 8'h14
`define SSR_ADDR_REM_DN 8'h18
`define SSR_ADDR_REMOTE 8'h1c
`define SSR_ADDR_LOCAL0 8'h20
`define SSR_ADDR_CGRP0 8'h30
`define SSR_ADDR_WORK 8'h40
`define SSR_ADDR_STATUS 8'h44

// mode register fields
`define SSR_MODE_REMOTE 0
`define SSR_MODE_AUTO 1
`define SSR_MODE_RUN 2
`define SSR_MODE_LOC_NOPROC 3
`define SSR_MODE_REM_NOPROC 4
`define SSR_MODE_LTYPE_LO 8
`define SSR_MODE_LTYPE_HI 11

// group register fields
`define SSR_GRP_COUNT_LO 0
`define SSR_GRP_COUNT_HI 2
`define SSR_GRP_SEL_LO 4
`define SSR_GRP_SEL_HI 6

// status register fields
`define SSR_ST_RAMPING 0
`define SSR_ST_ACTIVE_LO 4
`define SSR_ST_ACTIVE_HI 6
`define SSR_ST_CGRP_LO 8
`define SSR_ST_CGRP_HI 10

// reset values and limits
`define SSR_MODE_RST 12'h006
`define SSR_GRP_MAX 3'h4
`define SSR_GRP_COUNT_RST 3'h1
`define SSR_GRP_SEL_RST 3'h1
`define SSR_UNIT_RST 4'h0
`define SSR_UNIT_MAX 4'hb
`define SSR_RATE_MAX 15'h7d00
`define SSR_RATE_RST 15'h0000
`define SSR_CGRP_RST 3'h1
`define SSR_RAMP_OPCODE 7'h2a
`define SSR_TARGET_ALL 7'h00

// timing
`define SSR_CLK_NS 5
`define SSR_SEC_NS 1000000000
`define SSR_SEC_CYCLES 28'hbebc200
`define SSR_SECS_PER_S 22'h000001
`define SSR_SECS_PER_MIN 22'h00003c
`define SSR_SECS_PER_H 22'h000e10
`define SSR_RES_MUL1 22'h000001
`define SSR_RES_MUL10 22'h00000a
`define SSR_RES_MUL100 22'h000064
`define SSR_RES_MUL1000 22'h0003e8

`endif

// *** verilog/ssr_ramp_tick.v ***
`timescale 1ns/1ps
`include "ssr_defines.vh"

// ramp step timer: one pulse per time base, stretched by rate resolution
module ssr_ramp_tick #(
  parameter [27:0] SEC_CYCLES = `SSR_SEC_CYCLES
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // control
  input wire [3:0] unit_code,
  input wire restart,
  // timer output
  output reg tick
);

  reg [27:0] cyc_r;
  reg [21:0] sec_r;
  reg [21:0] base_secs;
  reg [21:0] res_mul;
  reg [43:0] prod;
  wire [21:0] period = prod[21:0];
  wire sec_end = (cyc_r == SEC_CYCLES - 28'h0000001);

  // code groups of three: s, min, h; resolution steps every three codes
  always @* begin
    case (unit_code)
      4'h0, 4'h3, 4'h6, 4'h9: base_secs = `SSR_SECS_PER_S;
      4'h1, 4'h4, 4'h7, 4'ha: base_secs = `SSR_SECS_PER_MIN;
      4'h2, 4'h5, 4'h8, 4'hb: base_secs = `SSR_SECS_PER_H;
      default: base_secs = `SSR_SECS_PER_S;
    endcase
    case (unit_code)
      4'h3, 4'h4, 4'h5: res_mul = `SSR_RES_MUL10;
      4'h6, 4'h7, 4'h8: res_mul = `SSR_RES_MUL100;
      4'h9, 4'ha, 4'hb: res_mul = `SSR_RES_MUL1000;
      default: res_mul = `SSR_RES_MUL1;
    endcase
    prod = base_secs * res_mul;
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 28'h0000000;
      sec_r <= 22'h000000;
      tick <= 1'b0;
    end else if (restart) begin
      cyc_r <= 28'h0000000;
      sec_r <= 22'h000000;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (sec_end) begin
        cyc_r <= 28'h0000000;
        if (sec_r >= period - 22'h000001) begin
          sec_r <= 22'h000000;
          tick <= 1'b1;
        end else begin
          sec_r <= sec_r + 22'h000001;
        end
      end else begin
        cyc_r <= cyc_r + 28'h0000001;
      end
    end
  end

endmodule

// *** bench/ssr_setpoint_chk.sv ***
`timescale 1ns/1ps
module ssr_setpoint_chk #(
  parameter [27:0] SEC_CYCLES = 28'h0000008,
  parameter [6:0] LOOP_ID = 7'h01
) (
  // clock and reset
  input wire clock,
  input wire rst_n,
  // register port
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // contact inputs
  input wire contact_on,
  input wire [6:0] contact_op,
  input wire [6:0] contact_target,
  input wire contact_grp_valid,
  input wire [7:0] contact_grp_sum,
  // setpoint outputs
  input wire [15:0] working_setpoint,
  input wire [2:0] active_group,
  input wire [2:0] control_constant_group,
  input wire ramping
);
  wire inh = contact_on && contact_op == 7'h2a
    && (contact_target == 7'h00 || contact_target == LOOP_ID);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  inhibit_idle_a: assert property (inh |=> !ramping)
    else $error("ramp running under inhibit");
  group_range_a: assert property (active_group >= 3'h1 && active_group <= 3'h4)
    else $error("active group out of range");
  group_sum0_a: assert property (contact_grp_valid && contact_grp_sum == 8'h00
    |=> active_group == 3'h1) else $error("zero weight sum not group one");
  status_rd_a: assert property (reg_rd && reg_addr == 8'h44 |=>
    reg_rdata[10:8] == $past(control_constant_group)
    && reg_rdata[6:4] == $past(active_group) && reg_rdata[0] == $past(ramping))
    else $error("status read mismatch");
  work_rd_a: assert property (reg_rd && reg_addr == 8'h40
    |=> reg_rdata[15:0] == $past(working_setpoint)) else $error("working read mismatch");
  unit_rd_a: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata <= 32'hb)
    else $error("unit code above eleven");
  rate_rd_a: assert property (reg_rd && reg_addr >= 8'h0c && reg_addr <= 8'h18
    |=> reg_rdata <= 32'h7d00) else $error("rate above limit");
  count_rd_a: assert property (reg_rd && reg_addr == 8'h04
    |=> reg_rdata[2:0] >= 3'h1 && reg_rdata[2:0] <= 3'h4) else $error("bad group count");
  cover property ($rose(ramping));
  cover property (ramping && inh);
  cover property (contact_grp_valid && active_group == 3'h4);
endmodule

bind ssr_setpoint_ramp ssr_setpoint_chk #(.SEC_CYCLES(SEC_CYCLES), .LOOP_ID(LOOP_ID)) i_chk (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .contact_on(contact_on), .contact_op(contact_op),
  .contact_target(contact_target), .contact_grp_valid(contact_grp_valid),
  .contact_grp_sum(contact_grp_sum), .working_setpoint(working_setpoint),
  .active_group(active_group), .control_constant_group(control_constant_group),
  .ramping(ramping));

// *** bench/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] process_value = 16'h0000;
  logic proc_range_err = 1'b0;
  logic contact_on = 1'b0;
  logic [6:0] contact_op = 7'h00;
  logic [6:0] contact_target = 7'h00;
  logic contact_grp_valid = 1'b0;
  logic [7:0] contact_grp_sum = 8'h00;
  logic [15:0] working_setpoint;
  logic [2:0] active_group;
  logic [2:0] control_constant_group;
  logic ramping;
  int err_count = 0;
  int cmp_count = 0;
  logic [31:0] d;
  int i;
  int cnt;
  logic [7:0] gsel [5] = '{8'h12, 8'h22, 8'h42, 8'h34, 8'h44};
  logic [2:0] ggrp [5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h4};
  logic [2:0] gcg [5] = '{3'h1, 3'h2, 3'h2, 3'h3, 3'h3};
  logic [11:0] pm1 [4] = '{12'h002, 12'h004, 12'h004, 12'h006};
  logic [11:0] pm2 [4] = '{12'h006, 12'h006, 12'h00e, 12'h106};
  logic [6:0] itgt [3] = '{7'h01, 7'h00, 7'h02};
  logic [7:0] csum [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05};
  logic [2:0] cexp [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4};

  always #2.5 clock = ~clock;

  ssr_setpoint_ramp #(.SEC_CYCLES(28'h0000008), .LOOP_ID(7'h01)) i_dut (
    .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .process_value(process_value), .proc_range_err(proc_range_err),
    .contact_on(contact_on), .contact_op(contact_op), .contact_target(contact_target),
    .contact_grp_valid(contact_grp_valid), .contact_grp_sum(contact_grp_sum),
    .working_setpoint(working_setpoint), .active_group(active_group),
    .control_constant_group(control_constant_group), .ramping(ramping));

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // collects every value the working setpoint takes within n cycles
  task automatic ramp_chk(input int st, input int tg, input int r, input int n);
    int v;
    int e[$];
    logic [15:0] q[$];
    logic [15:0] last;
    #1;
    v = st;
    if (working_setpoint !== st[15:0]) e.push_back(st);
    while (v != tg) begin
      v = (tg > v) ? ((tg - v > r) ? v + r : tg) : ((v - tg > r) ? v - r : tg);
      e.push_back(v);
    end
    last = working_setpoint;
    repeat (n) begin
      @(posedge clock);
      #1;
      if (working_setpoint !== last) q.push_back(working_setpoint);
      last = working_setpoint;
    end
    chk(q.size(), e.size(), "ramp step count");
    foreach (e[k]) if (k < q.size()) chk({16'h0, q[k]}, e[k], "ramp value");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    #1;
    chk(active_group, 3'h1, "reset group");
    chk(control_constant_group, 3'h1, "reset constant group");
    rd(8'h00);
    chk(d, 32'h006, "mode reset");
    rd(8'h48);
    chk(d, 32'h0, "unmapped read");
    $display("test reset done");
    for (i = 0; i < 13; i++) begin
      wr(8'h08, i);
      rd(8'h08);
      chk(d, (i > 11) ? 11 : i, "unit code");
    end
    wr(8'h08, 32'h0);
    for (i = 0; i < 4; i++) begin
      wr(8'h0c + 4 * i, 32'h7d01);
      rd(8'h0c + 4 * i);
      chk(d, 32'h7d00, "rate limit");
      wr(8'h0c + 4 * i, 32'h0);
      rd(8'h0c + 4 * i);
      chk(d, 32'h0, "rate zero");
    end
    $display("test settings done");
    for (i = 0; i < 4; i++) begin
      wr(8'h20 + 4 * i, 100 * (i + 1));
      wr(8'h30 + 4 * i, (i < 2) ? i + 1 : 3);
    end
    for (i = 0; i < 5; i++) begin
      wr(8'h04, gsel[i]);
      repeat (4) @(posedge clock);
      #1;
      chk(active_group, ggrp[i], "selected group");
      chk(control_constant_group, gcg[i], "constant group");
      chk(working_setpoint, 100 * ggrp[i], "step setpoint");
    end
    wr(8'h04, 32'h40);
    rd(8'h04);
    chk(d[2:0], 3'h1, "count zero");
    wr(8'h04, 32'h44);
    repeat (4) @(posedge clock);
    rd(8'h44);
    chk(d, 32'h340, "status read");
    rd(8'h40);
    chk(d, 32'd400, "working read");
    $display("test groups done");
    wr(8'h00, 32'h01e);
    wr(8'h0c, 32'd30);
    wr(8'h10, 32'd50);
    wr(8'h2c, 32'd500);
    ramp_chk(400, 500, 30, 100);
    wr(8'h2c, 32'd400);
    ramp_chk(500, 400, 50, 60);
    wr(8'h04, 32'h34);
    ramp_chk(400, 300, 50, 60);
    $display("test local ramp done");
    @(posedge clock);
    process_value <= 16'h0032;
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      proc_range_err <= (i == 1);
      wr(8'h00, pm1[i]);
      repeat (4) @(posedge clock);
      wr(8'h00, pm2[i]);
      ramp_chk((i == 0 || i == 3) ? 50 : 300, 300, 30, 120);
    end
    @(posedge clock);
    proc_range_err <= 1'b0;
    wr(8'h00, 32'h01e);
    $display("test process value start done");
    for (i = 0; i < 3; i++) begin
      wr(8'h28, (i == 1) ? 300 : 600);
      repeat (12) @(posedge clock);
      contact_op <= 7'h2a;
      contact_target <= itgt[i];
      contact_on <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      chk(ramping, i == 2, "ramp under contact");
      if (i != 2) chk(working_setpoint, (i == 1) ? 300 : 600, "aborted ramp");
      @(posedge clock);
      contact_on <= 1'b0;
      repeat (150) @(posedge clock);
    end
    $display("test inhibit done");
    wr(8'h14, 32'd20);
    wr(8'h18, 32'd40);
    wr(8'h1c, 32'd640);
    repeat (3) @(posedge clock);
    #1;
    chk(working_setpoint, 16'd600, "remote ignored in local");
    wr(8'h00, 32'h01f);
    ramp_chk(600, 640, 20, 60);
    wr(8'h1c, 32'd560);
    ramp_chk(640, 560, 40, 60);
    wr(8'h00, 32'h00d);
    @(posedge clock);
    process_value <= 16'h0208;
    wr(8'h00, 32'h00f);
    ramp_chk(520, 560, 20, 60);
    wr(8'h00, 32'h01e);
    ramp_chk(560, 600, 30, 60);
    $display("test remote done");
    wr(8'h08, 32'h3);
    wr(8'h28, 32'd630);
    #1;
    cnt = 0;
    while (working_setpoint === 16'd600 && cnt < 200) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    chk(cnt > 75 && cnt < 86, 1, "tenth resolution tick");
    wr(8'h08, 32'h0);
    $display("test unit timing done");
    @(posedge clock);
    contact_grp_valid <= 1'b1;
    for (i = 0; i < 5; i++) begin
      @(posedge clock);
      contact_grp_sum <= csum[i];
      repeat (3) @(posedge clock);
      #1;
      chk(active_group, cexp[i], "contact group");
    end
    $display("test contact group done");
    tally_and_finish;
  end
endmodule
